/* rtl/gdt_pkg.sv */
// Package for the gated / demodulation timer: mode codes, event
// select codes, widths, restart value and the configuration carrier.
// Assumes nothing of its surroundings; imported whole by each module except the pin model.
package gdt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int COUNT_W  = 16;
  localparam int PRESC_W  = 7;
  localparam int FILT_W   = 8;

  // ----------------------------------------------------------------
  // Mode field codes (mode field plus mode extension bit)
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_FIELD_GATED = 3'h6;
  localparam logic [2:0] MODE_FIELD_DEMOD = 3'h4;

  // ----------------------------------------------------------------
  // Interrupt event select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] IES_BOTH_A    = 2'h0;
  localparam logic [1:0] IES_BOTH_B    = 2'h1;
  localparam logic [1:0] IES_INPUT     = 2'h2;
  localparam logic [1:0] IES_RELOAD    = 2'h3;

  // ----------------------------------------------------------------
  // Counter values and reset values
  // ----------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RESTART = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_RESET   = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_FULL    = 7'h7f;
  localparam logic [PRESC_W-1:0] PRESC_RESET   = 7'h00;
  localparam logic [FILT_W-1:0]  FILT_FULL     = 8'hff;
  localparam logic [FILT_W-1:0]  FILT_RESET    = 8'h00;
  localparam logic [2:0]         SHIFT_TOP     = 3'h7;

  // ----------------------------------------------------------------
  // Configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic [2:0] mode_field;
    logic       mode_extension_bit;
    logic [2:0] prescale;
    logic [1:0] interrupt_event_select;
    logic       input_polarity;
    logic       dual_edge_capture;
    logic       out_alt_en;
    logic       filt_en;
    logic [2:0] filt_len;
  } gdt_cfg_t;

  // ----------------------------------------------------------------
  // Run state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } gdt_state_t;

endpackage : gdt_pkg

/* rtl/gdt_noise_filter.sv */
// Noise filter for the synchronised timer input.
// Assumes its input is already synchronised to sys_clk_in.
`timescale 1ns/100ps
`default_nettype none
module gdt_noise_filter
  import gdt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  // Sample and settings
  input  wire logic        sample_in,
  input  wire logic        filt_en_in,
  input  wire logic [2:0]  filt_len_in,
  // Filtered level
  output var  logic        filt_out
);

  logic [FILT_W-1:0] stable_cnt;
  wire  [FILT_W-1:0] thresh  = FILT_FULL >> (SHIFT_TOP - filt_len_in);
  wire               differs = sample_in != filt_out;
  wire               settled = stable_cnt == thresh;

  // A new level must persist 2^(len+1) samples; glitches restart the count
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stable_cnt <= FILT_RESET;
      filt_out   <= 1'b0;
    end
    else if (!filt_en_in || (differs && settled))
    begin
      stable_cnt <= FILT_RESET;
      filt_out   <= sample_in;
    end
    else if (differs)
      stable_cnt <= stable_cnt + 8'h01;
    else
      stable_cnt <= FILT_RESET;
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // bypass passes the sample straight on
  a_filter_bypass: assert property (!filt_en_in |=> filt_out == $past(sample_in))
    else $error("filter bypass did not follow the input");
  // a one-sample glitch is never passed with the filter on
  a_filter_glitch: assert property (filt_en_in && differs && stable_cnt == FILT_RESET
                                    && thresh != FILT_RESET |=> filt_out == $past(filt_out))
    else $error("filter passed a short glitch");

endmodule : gdt_noise_filter
`default_nettype wire

/* rtl/gdt_timer.sv */
// Sixteen-bit timer with gated and demodulation modes.
// Assumes configuration comes from same-clock logic and the timer
// input arrives from a pin, asynchronous to sys_clk_in.
//
// Summary of operation
// - Gated mode counts timer clock ticks up to the 16-bit reload value.
// - At reload, raise interrupt, restart at 0001H, keep counting if input asserted.
// - With output enabled, the timer output pin toggles at every reload.
// - Loaded start count applies to first pass; later passes start at 0001H.
// - Gated interrupt on deassertion and reload; select field can keep only one.
// - Polarity picks rising or falling capture edge unless dual-edge set.
// - Dual-edge capture bit captures on both input edges.
// - Demodulation interrupt on capture and reload; select field can keep one.
// - Demodulation counting starts at the first input transition after enable.
// - Optional noise filter on timer input, set by its own controls.
// - Counter advances once per 2^prescale timer clock cycles.
`timescale 1ns/100ps
`default_nettype none
module gdt_timer
  import gdt_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               arst_n_in,
  // Configuration
  input  wire gdt_cfg_t           cfg_in,
  input  wire logic [COUNT_W-1:0] reload_in,
  input  wire logic [COUNT_W-1:0] start_count_in,
  input  wire logic               count_load_in,
  // Timer input pin
  input  wire logic               timer_in,
  // Status and pins
  output var  logic [COUNT_W-1:0] count_out,
  output var  logic [COUNT_W-1:0] capture_out,
  output var  logic               timer_out_out,
  output var  logic               irq_out,
  output wire logic               running_out
);

  // ----------------------------------------------------------------
  // Input synchroniser and filter
  // ----------------------------------------------------------------
  logic tin_s1;
  logic tin_s2;
  logic tin_f;
  logic tin_prev;

  // Two flops before anything looks at the pin
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tin_s1 <= 1'b0;
      tin_s2 <= 1'b0;
    end
    else
    begin
      tin_s1 <= timer_in;
      tin_s2 <= tin_s1;
    end
  end

  gdt_noise_filter u_filter (
    .sys_clk_in  (sys_clk_in),
    .arst_n_in   (arst_n_in),
    .sample_in   (tin_s2),
    .filt_en_in  (cfg_in.filt_en),
    .filt_len_in (cfg_in.filt_len),
    .filt_out    (tin_f)
  );

  // Previous filtered level for edge detection
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tin_prev <= 1'b0;
    else
      tin_prev <= tin_f;
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  gdt_state_t        state;
  gdt_state_t        next_state;
  logic [PRESC_W-1:0] presc;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] capture;
  logic               tout;
  logic               irq;

  // demodulation only with the extension bit set as well
  wire is_gated = cfg_in.mode_field == MODE_FIELD_GATED && !cfg_in.mode_extension_bit;
  wire is_demod = cfg_in.mode_field == MODE_FIELD_DEMOD && cfg_in.mode_extension_bit;

  // Polarity set means the input is asserted low
  wire asserted      = tin_f ^ cfg_in.input_polarity;
  wire asserted_prev = tin_prev ^ cfg_in.input_polarity;
  wire rise          = tin_f && !tin_prev;
  wire fall          = !tin_f && tin_prev;
  wire any_edge      = rise || fall;

  wire pol_edge = cfg_in.input_polarity ? fall : rise;
  // dual-edge capture overrides the polarity choice
  wire cap_edge = cfg_in.dual_edge_capture ? any_edge : pol_edge;

  wire run = state == ST_RUN;

  // gated count is frozen while the input is deasserted
  // counting waits for the far side to assert the input
  wire count_en = run && (is_demod || (is_gated && asserted));

  // tick once every 2^prescale timer clocks
  wire [PRESC_W-1:0] presc_max = PRESC_FULL >> (SHIFT_TOP - cfg_in.prescale);
  wire               tick      = count_en && presc == presc_max;

  // terminal count is the 16-bit reload value
  wire at_reload = count == reload_in;
  wire reload_ev = tick && at_reload;

  // Input-side events: deassertion in gated, capture edge in demodulation
  wire deassert_ev = run && is_gated && asserted_prev && !asserted;
  wire capture_ev  = run && is_demod && cap_edge;
  wire input_ev    = deassert_ev || capture_ev;

  // select field may keep only one source in gated mode
  // the same selection applies to capture and reload
  wire irq_input  = input_ev && cfg_in.interrupt_event_select != IES_RELOAD;
  wire irq_reload = reload_ev && cfg_in.interrupt_event_select != IES_INPUT;

  // restart at 0001H after the terminal count
  wire [COUNT_W-1:0] count_inc  = count + 16'h0001;
  wire [COUNT_W-1:0] count_step = at_reload ? COUNT_RESTART : count_inc;

  // a loaded start value only shapes the pass it is loaded into
  wire [COUNT_W-1:0] next_count = count_load_in ? start_count_in
                                : tick          ? count_step
                                :                 count;

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  // enable is taken as the final step; disabling drops to idle
  // demodulation waits for the first input transition
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cfg_in.enable && is_gated)
          next_state = ST_RUN;
        else if (cfg_in.enable && is_demod)
          next_state = ST_WAIT;
      ST_WAIT:
        if (!cfg_in.enable || !is_demod)
          next_state = ST_IDLE;
        else if (any_edge)
          next_state = ST_RUN;
      ST_RUN:
        if (!cfg_in.enable || !(is_gated || is_demod))
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  // Prescaler clears whenever counting stops, so a gated pause restarts a full period
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      presc <= PRESC_RESET;
    else if (!count_en || tick)
      presc <= PRESC_RESET;
    else
      presc <= presc + 7'h01;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      count <= COUNT_RESET;
    else
      count <= next_count;
  end

  // ----------------------------------------------------------------
  // Capture, output pin and interrupt
  // ----------------------------------------------------------------
  // capture register takes the count at the chosen edge
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      capture <= COUNT_RESET;
    else if (capture_ev)
      capture <= count;
  end

  // output pin flips at each reload while the output function is on
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tout <= 1'b0;
    else if (reload_ev && cfg_in.out_alt_en)
      tout <= !tout;
  end

  // a selected input or reload event raises a one-cycle interrupt pulse
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      irq <= 1'b0;
    else
      irq <= irq_input || irq_reload;
  end

  assign count_out     = count;
  assign capture_out   = capture;
  assign timer_out_out = tout;
  assign irq_out       = irq;
  assign running_out   = state[2];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_count_advance: assert property (tick && !at_reload && !count_load_in
                                    |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance by one on a tick");

  // restart value, interrupt unless input-only select
  a_reload_restart: assert property (reload_ev && !count_load_in
    |=> count == COUNT_RESTART
        && (irq_out || $past(cfg_in.interrupt_event_select) == IES_INPUT))
    else $error("reload did not restart at one");

  a_out_toggle: assert property (reload_ev && cfg_in.out_alt_en
                                 |=> timer_out_out != $past(timer_out_out))
    else $error("output pin did not toggle at reload");

  a_out_steady: assert property (!(reload_ev && cfg_in.out_alt_en)
                                 |=> $stable(timer_out_out))
    else $error("output pin changed without a reload");

  a_start_load: assert property (count_load_in |=> count == $past(start_count_in))
    else $error("start count not loaded");

  a_irq_select: assert property (cfg_in.interrupt_event_select == IES_RELOAD
                                 && input_ev && !reload_ev |=> !irq_out)
    else $error("input event interrupt not suppressed");

  a_irq_reload_drop: assert property (cfg_in.interrupt_event_select == IES_INPUT
                                      && reload_ev && !input_ev |=> !irq_out)
    else $error("reload interrupt not suppressed");

  a_irq_input: assert property (input_ev && cfg_in.interrupt_event_select != IES_RELOAD
                                |=> irq_out)
    else $error("input event interrupt missing");

  a_capture_value: assert property (capture_ev |=> capture_out == $past(count))
    else $error("capture did not hold the count");

  a_capture_hold: assert property (!capture_ev |=> capture_out == $past(capture_out))
    else $error("capture changed without a capture edge");

  a_wait_hold: assert property (state == ST_WAIT && !count_load_in
                                |=> count == $past(count))
    else $error("counter moved before the first transition");

  // run starts only on a transition
  a_wait_start: assert property (state == ST_WAIT && !any_edge
                                 |=> !running_out)
    else $error("counting started without an input transition");

  a_presc_space: assert property (tick && cfg_in.prescale == 3'h2 && $stable(cfg_in)
                                  |=> !tick [*3])
    else $error("ticks closer than the prescale");

  a_gated_hold: assert property (run && is_gated && !asserted && !count_load_in
                                 |=> count == $past(count))
    else $error("gated counter moved while input deasserted");

  c_gated_reload: cover property (is_gated && reload_ev);
  c_demod_capture: cover property (is_demod && capture_ev && cfg_in.dual_edge_capture);
  c_gated_deassert: cover property (deassert_ev ##1 irq_out);
  c_demod_start: cover property (state == ST_WAIT ##1 state == ST_RUN);

endmodule : gdt_timer
`default_nettype wire

/* dv/gdt_pin_model.sv */
// Far-side model of whatever drives the timer input pin.
// Assumes requests change shortly after the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module gdt_pin_model
(
  // Clock
  input  wire logic sys_clk_in,
  // Request from the bench
  input  wire logic level_req_in,
  input  wire logic slow_in,
  // Pin level
  output var  logic pin_out
);
  logic lag = 1'b0;

  // Slow mode adds one cycle of lag; pulse widths stay exact
  always @(posedge sys_clk_in)
  begin
    lag <= level_req_in;
  end

  always_comb
  begin
    pin_out = slow_in ? lag : level_req_in;
  end
endmodule : gdt_pin_model
`default_nettype wire

/* dv/test_gated_demod_timer.sv */
// Self-checking bench for the gated / demodulation timer.
// Assumes the rtl package and the pin model beside this file.
`timescale 1ns/100ps
`default_nettype none
module test_gated_demod_timer
  import gdt_pkg::*;
;
  typedef struct packed {
    logic [1:0]         kind;
    logic [COUNT_W-1:0] val;
    logic               tout;
  } gdt_note_t;

  logic               sys_clk_in, arst_n_in, count_load_in, pin_req, slow, timer_in;
  logic               timer_out_out, irq_out, running_out;
  gdt_cfg_t           cfg;
  logic [COUNT_W-1:0] reload, start, count_out, capture_out;
  logic [COUNT_W-1:0] last_cap = '0;
  logic               tout = 1'b0;
  gdt_note_t          notes[$];
  gdt_note_t          nt;
  int                 num_errors = 0;
  int                 checks = 0;
  int                 seed = 86163;

  gdt_timer i_dut (
    .sys_clk_in    (sys_clk_in),
    .arst_n_in     (arst_n_in),
    .cfg_in        (cfg),
    .reload_in     (reload),
    .start_count_in(start),
    .count_load_in (count_load_in),
    .timer_in      (timer_in),
    .count_out     (count_out),
    .capture_out   (capture_out),
    .timer_out_out (timer_out_out),
    .irq_out       (irq_out),
    .running_out   (running_out)
  );

  gdt_pin_model i_pin (
    .sys_clk_in  (sys_clk_in),
    .level_req_in(pin_req),
    .slow_in     (slow),
    .pin_out     (timer_in)
  );

  // ------------------------------------------------------------------
  // Clock, checking and closing
  // ------------------------------------------------------------------
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Inputs move 1 ns after the edge so sampling never races
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc

  // Each interrupt pulse takes the oldest note; an empty queue is a stray pulse
  always @(posedge sys_clk_in)
  begin
    if (irq_out === 1'b1)
    begin
      if (notes.size() == 0)
        check("stray_irq", 16'h0001, 16'h0000);
      else
      begin
        nt = notes.pop_front();
        if (nt.kind == 2'h0)
        begin
          check("count_at_irq", count_out, nt.val);
          check("timer_out", {15'h0, timer_out_out}, {15'h0, nt.tout});
        end
        else if (nt.kind == 2'h1)
          check("capture_delta", capture_out - last_cap, nt.val);
        if (nt.kind != 2'h0)
          last_cap = capture_out;
      end
    end
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic load_and_enable;
    count_load_in = 1'b1;
    cyc(1);
    count_load_in = 1'b0;
    cyc(5);
    cfg.enable = 1'b1;
  endtask : load_and_enable

  task automatic run_gated(input logic [1:0] ies);
    logic pol;
    int   n, r, s, c;
    pol = 1'($random(seed));
    slow = 1'($random(seed));
    r = 5 + $unsigned($random(seed)) % 12;
    s = $unsigned($random(seed)) % r;
    n = 10 + $unsigned($random(seed)) % 30;
    cfg = '0;
    cfg.mode_field = MODE_FIELD_GATED;
    cfg.interrupt_event_select = ies;
    cfg.input_polarity = pol;
    cfg.out_alt_en = 1'b1;
    reload = r[15:0];
    start = s[15:0];
    pin_req = pol;
    load_and_enable();
    cyc(5);
    check("running", {15'h0, running_out}, 16'h0001);
    // first pass from the loaded count, later passes from one
    c = s;
    for (int i = 0; i < n; i++)
      if (c == r)
      begin
        c = 1;
        tout = ~tout;
        if (ies != IES_INPUT)
          notes.push_back({2'h0, COUNT_RESTART, tout});
      end
      else
        c++;
    if (ies != IES_RELOAD)
      notes.push_back({2'h0, c[15:0], tout});
    pin_req = ~pol;
    cyc(n);
    pin_req = pol;
    cyc(20);
    check("held_count", count_out, c[15:0]);
    cfg.enable = 1'b0;
    cyc(3);
  endtask : run_gated

  task automatic run_demod(input logic pol, input logic dual, input logic [1:0] ies,
                           input logic filt);
    logic lvl, first;
    int   p, h, l, dt;
    // Prescale follows the call's pol and dual bits so all four values are run
    p = int'({pol, dual});
    h = 8 * (2 + $unsigned($random(seed)) % 4);
    l = h + 8 * (1 + $unsigned($random(seed)) % 3);
    slow = 1'($random(seed));
    // compare values live outside this block; set-up starts from all zero
    cfg = '0;
    cfg.mode_field = MODE_FIELD_DEMOD;
    cfg.mode_extension_bit = 1'b1;
    cfg.prescale = p[2:0];
    cfg.interrupt_event_select = ies;
    cfg.input_polarity = pol;
    cfg.dual_edge_capture = dual;
    cfg.filt_en = filt;
    // Filter lengths up to 8 samples stay well inside the pulse widths
    if (filt)
      cfg.filt_len = 3'($unsigned($random(seed)) % 3);
    reload = 16'hffff;
    start = 16'($random(seed)) & 16'h00ff;
    pin_req = 1'b0;
    load_and_enable();
    cyc(10);
    check("wait_count", count_out, start);
    pin_req = 1'b1;
    cyc(h);
    lvl = 1'b1;
    first = 1'b1;
    dt = 0;
    // selected edges capture, deltas scale by prescale
    for (int e = 0; e < 7; e++)
    begin
      lvl = ~lvl;
      pin_req = lvl;
      if ((dual | (lvl ^ pol)) && ies != IES_RELOAD)
      begin
        notes.push_back({first ? 2'h2 : 2'h1, 16'(dt >> p), 1'b0});
        first = 1'b0;
        dt = 0;
      end
      dt += lvl ? h : l;
      cyc(lvl ? h : l);
    end
    cyc(20);
    cfg.enable = 1'b0;
    cyc(3);
  endtask : run_demod

  // Watchdog: the whole run needs well under 10000 cycles
  initial
  begin
    repeat (10000) @(posedge sys_clk_in);
    num_errors++;
    stop_test();
  end

  initial
  begin
    arst_n_in = 1'b0;
    cfg = '0;
    reload = '0;
    start = '0;
    count_load_in = 1'b0;
    pin_req = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1 arst_n_in = 1'b1;
    cyc(2);
    check("reset_count", count_out, COUNT_RESET);
    for (int k = 0; k < 8; k++)
      run_gated(k[1:0]);
    // Reset between the gated and demodulation runs clears the counter, the run state and the output pin
    arst_n_in = 1'b0;
    cyc(2);
    arst_n_in = 1'b1;
    tout = 1'b0;
    cyc(2);
    check("mid_reset_count", count_out, COUNT_RESET);
    check("mid_reset_tout", {15'h0, timer_out_out}, 16'h0000);
    check("mid_reset_run", {15'h0, running_out}, 16'h0000);
    run_demod(1'b0, 1'b0, IES_BOTH_A, 1'b0);
    run_demod(1'b1, 1'b0, IES_BOTH_B, 1'b0);
    run_demod(1'b0, 1'b1, IES_INPUT, 1'b1);
    run_demod(1'b1, 1'b1, IES_RELOAD, 1'b0);
    check("missing_irq", 16'(notes.size()), 16'h0000);
    stop_test();
  end
endmodule : test_gated_demod_timer
`default_nettype wire
